// ### logic/axis_cfg_pkg.sv
package axis_cfg_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_AXES   = 5;
  localparam int SHARED_AX  = 4;
  localparam int ADDR_W     = 6;
  localparam int DATA_W     = 32;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_UNIT_DECEL  = 6'h00;
  localparam logic [5:0] OFS_WIRING_BLK  = 6'h04;
  localparam logic [5:0] OFS_DIR_POL     = 6'h08;
  localparam logic [5:0] OFS_ALARM_POL   = 6'h0C;
  localparam logic [5:0] OFS_BACKLASH    = 6'h10;
  localparam logic [5:0] OFS_BL_KEYLOCK  = 6'h14;
  localparam logic [5:0] OFS_LIMIT_PWR   = 6'h18;
  localparam logic [5:0] OFS_OUT_FORMAT  = 6'h1C;
  localparam logic [5:0] OFS_HOME_TYPE   = 6'h20;
  localparam logic [5:0] OFS_HOME_DIR    = 6'h24;
  localparam logic [5:0] OFS_CONTROL     = 6'h28;
  localparam logic [5:0] OFS_INPUT_UNIT  = 6'h2C;
  localparam logic [5:0] OFS_STATUS      = 6'h30;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int UNIT_BIT       = 0;
  localparam int DECEL_LSB      = 3;
  localparam int SHARED_LSB     = 0;
  localparam int BLOCK_WAIT_BIT = 5;
  localparam int WAVE_BIT       = 7;
  localparam int RETAIN_BIT     = 7;
  localparam int RESTART_BIT    = 0;
  localparam int HOME_GO_LSB    = 8;
  localparam int INCH_CMD_BIT   = 0;
  localparam int ST_ACT_UNIT    = 0;
  localparam int ST_IN_INCH     = 1;
  localparam int ST_BUSY_LSB    = 8;
  localparam int ST_DONE_LSB    = 16;
  localparam int ST_FMT_LSB     = 24;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_RESET = 8'h00;
  // ---------------------------------------------------------------
  // Homing sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    H_IDLE    = 6'b000001,
    H_RAPID   = 6'b000010,
    H_PASS    = 6'b000100,
    H_REVERSE = 6'b001000,
    H_CREEP   = 6'b010000,
    H_SEEK    = 6'b100000
  } home_state_type;
endpackage : axis_cfg_pkg

// ### logic/axis_pulse_and_homing_config.sv
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
// Notes on behaviour
// - Output units are inch when the unit bit is set and metric when clear, applied only on restart.
// - The applied unit bit states whether increments, parameters and pitch values are inch or mm.
// - A G21 command makes input increments metric and G20 makes them inch, apart from output units.
// - Each axis deceleration input is active high when its polarity bit is 1, else active low.
// - Each axis emits quadrature when its format bit is 1, else pulse and direction, after restart.
// - The waveform bit selects a pulse waveform when set and a square waveform when clear.
// - Each axis homes with type C when its homing-type bit is 1, else with type B.
// - With the shared-switch bit set, one switch serves as both deceleration and zero signal.
// - With the shared-switch bit clear, separate deceleration and zero inputs are used.
// - With block wait set, the next block starts only once all motion is finished, else it blends.
// - Homing runs positive when an axis direction bit is 0 and negative when it is 1.
// - With offset retain set the length offset stays on during homing, else it is cancelled.
// - Homing runs at rapid until deceleration (type C until the deceleration input releases), then at low speed until the zero signal changes.
module axis_pulse_and_homing_config
(
  // Clock and reset
  input  wire logic                                 i_clk_sys,
  input  wire logic                                 i_sys_rst,
  // Avalon-MM slave
  input  wire logic [axis_cfg_pkg::ADDR_W-1:0]      i_address,
  input  wire logic                                 i_read,
  input  wire logic                                 i_write,
  input  wire logic [3:0]                           i_byteenable,
  input  wire logic [axis_cfg_pkg::DATA_W-1:0]      i_writedata,
  output logic      [axis_cfg_pkg::DATA_W-1:0]      o_readdata,
  output logic                                      o_waitrequest,
  // Machine switch pins
  input  wire logic [axis_cfg_pkg::NUM_AXES-1:0]    i_decel_pin,
  input  wire logic [axis_cfg_pkg::NUM_AXES-1:0]    i_one_rotation_zero_input,
  // Block sequencing
  input  wire logic                                 i_next_block_req,
  input  wire logic                                 i_motion_busy,
  output logic                                      o_next_block_start,
  // Applied configuration
  output logic                                      o_output_unit_inch,
  output logic                                      o_input_unit_inch,
  output logic [axis_cfg_pkg::NUM_AXES-1:0]         o_pulse_output_quad,
  output logic                                      o_step_waveform_pulse,
  output logic                                      o_length_offset_apply,
  // Homing motion per axis
  output logic [axis_cfg_pkg::NUM_AXES-1:0]         o_home_move,
  output logic [axis_cfg_pkg::NUM_AXES-1:0]         o_home_fast,
  output logic [axis_cfg_pkg::NUM_AXES-1:0]         o_home_dir_neg,
  output logic [axis_cfg_pkg::NUM_AXES-1:0]         o_home_done
);
  import axis_cfg_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0]          unit_and_decel_polarity_cfg_q;
  logic [7:0]          homing_wiring_and_block_cfg_q;
  logic [7:0]          direction_polarity_cfg_q;
  logic [7:0]          alarm_polarity_cfg_q;
  logic [7:0]          backlash_rate_cfg_q;
  logic [7:0]          backlash_and_key_lock_cfg_q;
  logic [7:0]          limit_and_powerup_cfg_q;
  logic [7:0]          pulse_output_format_q;
  logic [7:0]          homing_type_select_q;
  logic [7:0]          homing_direction_select_q;
  logic                wait_q;
  logic [DATA_W-1:0]   rdata_q;
  logic                access;
  logic                wr_take;
  logic                wr_lane0;
  logic                restart_wr;
  logic                inch_cmd_wr;
  logic                act_unit_q;
  logic                in_inch_q;
  logic [NUM_AXES-1:0] act_fmt_q;
  logic [NUM_AXES-1:0] decel_s1_q;
  logic [NUM_AXES-1:0] decel_s2_q;
  logic [NUM_AXES-1:0] zero_s1_q;
  logic [NUM_AXES-1:0] zero_s2_q;
  logic [NUM_AXES-1:0] decel_act_q;
  logic [NUM_AXES-1:0] home_go;
  logic [NUM_AXES-1:0] home_busy;
  logic [NUM_AXES-1:0] home_done;
  logic [NUM_AXES-1:0] home_move;
  logic [NUM_AXES-1:0] home_fast;
  logic [NUM_AXES-1:0] home_dir;
  logic [DATA_W-1:0]   rmux;
  logic                blk_start_q;
  logic                wave_q;
  logic                len_apply_q;

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // One wait cycle: waitrequest drops for the edge that completes
  assign access      = i_read | i_write;
  assign wr_take     = i_write & ~wait_q;
  assign wr_lane0    = wr_take & i_byteenable[0];
  assign restart_wr  = wr_lane0 && (i_address == OFS_CONTROL)
                       && i_writedata[RESTART_BIT];
  assign inch_cmd_wr = wr_lane0 && (i_address == OFS_INPUT_UNIT);

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst) wait_q <= 1'b1;
    else           wait_q <= ~(access & wait_q);
  end

  // Read data is captured while waitrequest is still high
  always_comb
  begin
    rmux = '0;
    unique case (i_address)
      OFS_UNIT_DECEL: rmux[7:0] = unit_and_decel_polarity_cfg_q;
      OFS_WIRING_BLK: rmux[7:0] = homing_wiring_and_block_cfg_q;
      OFS_DIR_POL:    rmux[7:0] = direction_polarity_cfg_q;
      OFS_ALARM_POL:  rmux[7:0] = alarm_polarity_cfg_q;
      OFS_BACKLASH:   rmux[7:0] = backlash_rate_cfg_q;
      OFS_BL_KEYLOCK: rmux[7:0] = backlash_and_key_lock_cfg_q;
      OFS_LIMIT_PWR:  rmux[7:0] = limit_and_powerup_cfg_q;
      OFS_OUT_FORMAT: rmux[7:0] = pulse_output_format_q;
      OFS_HOME_TYPE:  rmux[7:0] = homing_type_select_q;
      OFS_HOME_DIR:   rmux[7:0] = homing_direction_select_q;
      OFS_INPUT_UNIT: rmux[INCH_CMD_BIT] = in_inch_q;
      OFS_STATUS:
      begin
        rmux[ST_ACT_UNIT] = act_unit_q;
        rmux[ST_IN_INCH]  = in_inch_q;
        rmux[ST_BUSY_LSB +: NUM_AXES] = home_busy;
        rmux[ST_DONE_LSB +: NUM_AXES] = home_done;
        rmux[ST_FMT_LSB +: NUM_AXES]  = act_fmt_q;
      end
      default:        rmux = '0;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)                rdata_q <= '0;
    else if (i_read && wait_q)    rdata_q <= rmux;
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Writes land on the completing edge, low byte lane only
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      unit_and_decel_polarity_cfg_q <= CFG_RESET;
      homing_wiring_and_block_cfg_q <= CFG_RESET;
      direction_polarity_cfg_q      <= CFG_RESET;
      alarm_polarity_cfg_q          <= CFG_RESET;
      backlash_rate_cfg_q           <= CFG_RESET;
      backlash_and_key_lock_cfg_q   <= CFG_RESET;
      limit_and_powerup_cfg_q       <= CFG_RESET;
      pulse_output_format_q         <= CFG_RESET;
      homing_type_select_q          <= CFG_RESET;
      homing_direction_select_q     <= CFG_RESET;
    end
    else if (wr_lane0)
    begin
      unique case (i_address)
        OFS_UNIT_DECEL: unit_and_decel_polarity_cfg_q <= i_writedata[7:0];
        OFS_WIRING_BLK: homing_wiring_and_block_cfg_q <= i_writedata[7:0];
        OFS_DIR_POL:    direction_polarity_cfg_q      <= i_writedata[7:0];
        OFS_ALARM_POL:  alarm_polarity_cfg_q          <= i_writedata[7:0];
        OFS_BACKLASH:   backlash_rate_cfg_q           <= i_writedata[7:0];
        OFS_BL_KEYLOCK: backlash_and_key_lock_cfg_q   <= i_writedata[7:0];
        OFS_LIMIT_PWR:  limit_and_powerup_cfg_q       <= i_writedata[7:0];
        OFS_OUT_FORMAT: pulse_output_format_q         <= i_writedata[7:0];
        OFS_HOME_TYPE:  homing_type_select_q          <= i_writedata[7:0];
        OFS_HOME_DIR:   homing_direction_select_q     <= i_writedata[7:0];
        default:        ;
      endcase
    end
  end

  // Unit and pulse format only take effect on a restart command
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      act_unit_q <= 1'b0;
      act_fmt_q  <= '0;
    end
    else if (restart_wr)
    begin
      act_unit_q <= unit_and_decel_polarity_cfg_q[UNIT_BIT];
      act_fmt_q  <= pulse_output_format_q[NUM_AXES-1:0];
    end
  end

  // G20 writes 1, G21 writes 0; independent of output units
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)        in_inch_q <= 1'b0;
    else if (inch_cmd_wr) in_inch_q <= i_writedata[INCH_CMD_BIT];
  end

  // ---------------------------------------------------------------
  // Pin synchronisers and deceleration polarity
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      decel_s1_q <= '0;
      decel_s2_q <= '0;
      zero_s1_q  <= '0;
      zero_s2_q  <= '0;
    end
    else
    begin
      decel_s1_q <= i_decel_pin;
      decel_s2_q <= decel_s1_q;
      zero_s1_q  <= i_one_rotation_zero_input;
      zero_s2_q  <= zero_s1_q;
    end
  end

  // Active when the pin level matches the polarity bit
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst) decel_act_q <= '0;
    else           decel_act_q <= ~(decel_s2_q ^
                     unit_and_decel_polarity_cfg_q[DECEL_LSB +: NUM_AXES]);
  end

  // ---------------------------------------------------------------
  // Homing sequencers, one per axis
  // ---------------------------------------------------------------
  generate
    for (genvar ax = 0; ax < NUM_AXES; ax++)
    begin : g_axis
      homing_if hif ();
      assign home_go[ax]    = wr_lane0 && (i_address == OFS_CONTROL)
                              && i_writedata[HOME_GO_LSB + ax];
      assign hif.start      = home_go[ax];
      assign hif.type_c     = homing_type_select_q[ax];
      assign hif.dir_neg    = homing_direction_select_q[ax];
      assign hif.decel_act  = decel_act_q[ax];
      assign hif.zero_lvl   = zero_s2_q[ax];
      // The fifth axis has no shared-switch option
      if (ax < SHARED_AX)
      begin : g_sh
        assign hif.shared = homing_wiring_and_block_cfg_q[SHARED_LSB + ax];
      end
      else
      begin : g_nsh
        assign hif.shared = 1'b0;
      end
      assign home_busy[ax]  = hif.busy;
      assign home_done[ax]  = hif.done;
      assign home_move[ax]  = hif.move;
      assign home_fast[ax]  = hif.fast;
      assign home_dir[ax]   = hif.dir;
      homing_seq u_seq
      (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .hif       (hif)
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Block sequencing, waveform and length offset
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      blk_start_q <= 1'b0;
      wave_q      <= 1'b0;
      len_apply_q <= 1'b1;
    end
    else
    begin
      blk_start_q <= i_next_block_req &&
                     (!homing_wiring_and_block_cfg_q[BLOCK_WAIT_BIT] ||
                      (!i_motion_busy && home_busy == '0));
      wave_q      <= pulse_output_format_q[WAVE_BIT];
      len_apply_q <= (home_busy == '0) ||
                     homing_direction_select_q[RETAIN_BIT];
    end
  end

  assign o_readdata            = rdata_q;
  assign o_waitrequest         = wait_q;
  assign o_next_block_start    = blk_start_q;
  assign o_output_unit_inch    = act_unit_q;
  assign o_input_unit_inch     = in_inch_q;
  assign o_pulse_output_quad   = act_fmt_q;
  assign o_step_waveform_pulse = wave_q;
  assign o_length_offset_apply = len_apply_q;
  assign o_home_move           = home_move;
  assign o_home_fast           = home_fast;
  assign o_home_dir_neg        = home_dir;
  assign o_home_done           = home_done;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_unit_on_restart;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    !restart_wr |=> $stable(act_unit_q) && $stable(act_fmt_q);
  endproperty
  a_unit_on_restart: assert property (p_unit_on_restart)
    else $error("applied unit or format changed without restart");

  property p_fmt_from_cfg;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    restart_wr |=> act_fmt_q == $past(pulse_output_format_q[NUM_AXES-1:0]);
  endproperty
  a_fmt_from_cfg: assert property (p_fmt_from_cfg)
    else $error("pulse format not applied on restart");

  property p_input_unit;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    inch_cmd_wr |=> (in_inch_q == $past(i_writedata[INCH_CMD_BIT]))
      && $stable(act_unit_q);
  endproperty
  a_input_unit: assert property (p_input_unit)
    else $error("input unit command not applied");

  property p_block_wait;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    homing_wiring_and_block_cfg_q[BLOCK_WAIT_BIT] && i_motion_busy
      && $stable(homing_wiring_and_block_cfg_q) |=> !blk_start_q;
  endproperty
  a_block_wait: assert property (p_block_wait)
    else $error("block started while motion still busy");

  property p_offset_cancel;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (home_busy != '0) && !homing_direction_select_q[RETAIN_BIT] |=> !len_apply_q;
  endproperty
  a_offset_cancel: assert property (p_offset_cancel)
    else $error("length offset kept during homing");

  property p_bus_answer;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    access && wait_q |=> !wait_q ##1 wait_q;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not one cycle after request");
endmodule : axis_pulse_and_homing_config

// ### logic/homing_if.sv
`timescale 1ns/1ns
interface homing_if;
  logic start;
  logic type_c;
  logic shared;
  logic dir_neg;
  logic decel_act;
  logic zero_lvl;
  logic move;
  logic fast;
  logic dir;
  logic busy;
  logic done;
  // Configuration side
  modport ctrl (output start, type_c, shared, dir_neg, decel_act, zero_lvl,
                input  move, fast, dir, busy, done);
  // Sequencer side
  modport seq  (input  start, type_c, shared, dir_neg, decel_act, zero_lvl,
                output move, fast, dir, busy, done);
endinterface : homing_if

// ### logic/homing_seq.sv
`timescale 1ns/1ns
module homing_seq
(
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  // Link to configuration logic
  homing_if.seq     hif
);
  import axis_cfg_pkg::*;

  home_state_type state_q;
  home_state_type state_d;
  logic           zero_now;
  logic           zero_prev_q;
  logic           rev_q;
  logic           move_q;
  logic           fast_q;
  logic           dir_q;
  logic           busy_q;
  logic           done_q;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Zero reference comes from the shared switch or the rotation input
  assign zero_now = hif.shared ? hif.decel_act : hif.zero_lvl;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      H_IDLE:    if (hif.start) state_d = H_RAPID;
      H_RAPID:   if (hif.decel_act) state_d = hif.type_c ? H_PASS : H_CREEP;
      H_PASS:    if (!hif.decel_act) state_d = H_REVERSE;
      H_REVERSE: if (hif.decel_act) state_d = hif.shared ? H_SEEK : H_CREEP;
      H_CREEP:   if (!hif.decel_act) state_d = H_SEEK;
      H_SEEK:    if (zero_now != zero_prev_q) state_d = H_IDLE;
      default:   state_d = H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst) state_q <= H_IDLE;
    else           state_q <= state_d;
  end

  // Previous zero level for change detection
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst) zero_prev_q <= 1'b0;
    else           zero_prev_q <= zero_now;
  end

  // ---------------------------------------------------------------
  // Registered motion outputs
  // ---------------------------------------------------------------
  // Type C reverses after passing the switch
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rev_q  <= 1'b0;
      move_q <= 1'b0;
      fast_q <= 1'b0;
      dir_q  <= 1'b0;
    end
    else
    begin
      rev_q  <= (state_d == H_IDLE) ? 1'b0 : (rev_q | (state_d == H_REVERSE));
      move_q <= (state_d != H_IDLE);
      fast_q <= (state_d == H_RAPID) || (state_d == H_PASS);
      dir_q  <= hif.dir_neg ^ (rev_q | (state_d == H_REVERSE));
    end
  end

  // Busy and sticky done; a new start clears done
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      busy_q <= (state_d != H_IDLE);
      if (state_q == H_SEEK && state_d == H_IDLE) done_q <= 1'b1;
      else if (state_q == H_IDLE && hif.start)    done_q <= 1'b0;
    end
  end

  assign hif.move = move_q;
  assign hif.fast = fast_q;
  assign hif.dir  = dir_q;
  assign hif.busy = busy_q;
  assign hif.done = done_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_rapid_until_decel;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (state_q == H_RAPID) && !hif.decel_act |=> fast_q && move_q;
  endproperty
  a_rapid_until_decel: assert property (p_rapid_until_decel)
    else $error("rapid traverse dropped before deceleration input");

  property p_type_c_path;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (state_q == H_RAPID) && hif.decel_act |=>
      (hif.type_c ? state_q == H_PASS : (state_q == H_CREEP && !fast_q));
  endproperty
  a_type_c_path: assert property (p_type_c_path)
    else $error("homing type path taken wrongly");

  property p_home_dir;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (state_q == H_RAPID) ##1 (state_q == H_RAPID) && $stable(hif.dir_neg)
      |-> dir_q == hif.dir_neg;
  endproperty
  a_home_dir: assert property (p_home_dir)
    else $error("homing direction wrong during rapid approach");

  property p_shared_stop;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (state_q == H_SEEK) && hif.shared && (hif.decel_act != zero_prev_q)
      |=> (state_q == H_IDLE) && done_q;
  endproperty
  a_shared_stop: assert property (p_shared_stop)
    else $error("shared switch change did not stop homing");
endmodule : homing_seq

// ### tb/switch_model.sv
`timescale 1ns/1ns
module switch_model
(
  // Axis motion
  input  wire logic i_clk_sys,
  input  wire logic i_move,
  input  wire logic i_dir_neg,
  input  wire logic i_home_neg,
  input  wire logic i_act_high,
  // Switch levels
  output logic      o_decel,
  output logic      o_zero
);
  int pos_q;
  // Travel runs away from the start, and back once the axis reverses
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_move)
      pos_q <= 0;
    else if (i_dir_neg == i_home_neg)
      pos_q <= pos_q + 1;
    else
      pos_q <= pos_q - 1;
  end
  // Dog pressed over a stretch of travel, at the configured level
  assign o_decel = ((pos_q > 20) && (pos_q < 40)) ~^ i_act_high;
  // Separate one-rotation level toggles every 8 cycles of travel
  assign o_zero = pos_q[3];
endmodule : switch_model

// ### tb/test_axis_pulse_and_homing_config.sv
`timescale 1ns/1ns
module test_axis_pulse_and_homing_config;
  import axis_cfg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic dec0;
  logic zr0;
  logic req = 1'b0;
  logic home_neg = 1'b1;
  logic busy = 1'b0;
  logic nstart, out_inch, in_inch, wave, ofs;
  logic [4:0] quad, move, fast, dneg, done;
  logic [31:0] rv;
  int errors = 0;
  int tests_run = 0;
  // Clock
  always #20 clk = ~clk;
  axis_pulse_and_homing_config u_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_address(address),
    .i_read(read), .i_write(write), .i_byteenable(4'hF), .i_writedata(wdata),
    .o_readdata(rdata), .o_waitrequest(waitreq), .i_decel_pin({4'h0, dec0}),
    .i_one_rotation_zero_input({4'h0, zr0}), .i_next_block_req(req), .i_motion_busy(busy),
    .o_next_block_start(nstart), .o_output_unit_inch(out_inch), .o_input_unit_inch(in_inch),
    .o_pulse_output_quad(quad), .o_step_waveform_pulse(wave), .o_length_offset_apply(ofs),
    .o_home_move(move), .o_home_fast(fast), .o_home_dir_neg(dneg), .o_home_done(done));
  switch_model u_sw (.i_clk_sys(clk), .i_move(move[0]), .i_dir_neg(dneg[0]),
    .i_home_neg(home_neg), .i_act_high(1'b1), .o_decel(dec0), .o_zero(zr0));
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Verdict
  task results;
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  // One Avalon transfer, held until waitrequest is seen low
  task bus(input logic we, input logic [5:0] a, input logic [31:0] d);
    address <= a;
    wdata <= d;
    write <= we;
    read <= ~we;
    @(posedge clk);
    while (waitreq !== 1'b0)
      @(posedge clk);
    rv = rdata;
    write <= 1'b0;
    read <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : bus
  // Watchdog
  initial
  begin
    #100000;
    errors++;
    results();
  end
  // Tests
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(ofs, 1);
    bus(0, OFS_UNIT_DECEL, 0);
    chk(rv, 0);
    bus(1, OFS_UNIT_DECEL, 32'h09);
    bus(1, OFS_OUT_FORMAT, 32'h85);
    chk(out_inch, 0);
    chk(quad, 0);
    chk(wave, 1);
    bus(1, OFS_CONTROL, 32'h01);
    chk(out_inch, 1);
    chk(quad, 5);
    bus(0, OFS_STATUS, 0);
    chk(rv[0], 1);
    bus(1, OFS_INPUT_UNIT, 32'h01);
    chk(in_inch, 1);
    bus(1, OFS_INPUT_UNIT, 32'h00);
    chk(in_inch, 0);
    bus(0, 6'h34, 0);
    chk(rv, 0);
    bus(1, OFS_WIRING_BLK, 32'h20);
    req <= 1'b1;
    busy <= 1'b1;
    repeat (3) @(posedge clk);
    chk(nstart, 0);
    busy <= 1'b0;
    repeat (3) @(posedge clk);
    chk(nstart, 1);
    req <= 1'b0;
    bus(1, OFS_WIRING_BLK, 32'h00);
    bus(1, OFS_HOME_DIR, 32'h01);
    bus(1, OFS_CONTROL, 32'h100);
    chk({move[0], fast[0], dneg[0], ofs}, 4'hE);
    repeat (30) @(posedge clk);
    chk({move[0], fast[0]}, 2'h2);
    for (int i = 0; i < 200 && done[0] !== 1'b1; i++)
      @(posedge clk);
    @(posedge clk);
    chk({move[0], done[0], ofs}, 3'h3);
    home_neg <= 1'b0;
    bus(1, OFS_WIRING_BLK, 32'h01);
    bus(1, OFS_HOME_TYPE, 32'h01);
    bus(1, OFS_HOME_DIR, 32'h80);
    bus(1, OFS_CONTROL, 32'h100);
    repeat (45) @(posedge clk);
    chk({move[0], fast[0], dneg[0], ofs}, 4'hB);
    for (int i = 0; i < 200 && done[0] !== 1'b1; i++)
      @(posedge clk);
    @(posedge clk);
    chk({move[0], done[0], ofs}, 3'h3);
    results();
  end
endmodule : test_axis_pulse_and_homing_config
